//--- core/ffal_core.sv
// FIFO address counters, fill-level difference and flag logic, with an
// entry buffer in front of the write side.
// Assumes write and read user logic share clk_i; clear arrives from a pin.
`timescale 1ns/10ps

module ffal_buf import ffal_pkg::*; #(
    parameter int DW = FFAL_DEF_DW,
    parameter int DEPTH = FFAL_BUF_DEPTH
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [DW-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [DW-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] mem; // Word storage
        logic [AW-1:0] wr;             // Write index
        logic [AW-1:0] rd;             // Read index
        logic [AW:0] cnt;              // Words held
        logic rdy;                     // Registered ready
    } ffal_buf_s;

    ffal_buf_s s_q, s_d;
    logic push, pop; // Handshakes this cycle

    assign out_valid_o = (s_q.cnt != '0);
    assign out_data_o = s_q.mem[s_q.rd];
    assign in_ready_o = s_q.rdy;

    // Next state: ready is registered, so it looks at the next count
    always_comb begin
        s_d = s_q;
        push = in_valid_i && s_q.rdy;
        pop = out_valid_o && out_ready_i;
        if (push) begin
            s_d.mem[s_q.wr] = in_data_i;
            s_d.wr = (s_q.wr == AW'(DEPTH-1)) ? '0 : s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = (s_q.rd == AW'(DEPTH-1)) ? '0 : s_q.rd + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        s_d.rdy = (s_d.cnt < FULL_CNT);
    end

    // State register with synchronous reset
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : ffal_buf

module ffal_core import ffal_pkg::*; #(
    parameter int DW = FFAL_DEF_DW,
    parameter int MEM_WORDS = FFAL_REF_DEPTH,
    parameter int BUF_DEPTH = FFAL_BUF_DEPTH
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic clr_pin_i,                // Asynchronous clear pin
    input wire logic [2:0] width_sel_i,        // 0 widest .. 5 narrowest
    input wire logic [2:0] casc_sel_i,         // 0..4 = 1..16 blocks
    input wire logic pipelined_i,              // Extra read data stage
    input wire logic [7:0] almost_full_threshold_i,
    input wire logic [7:0] almost_empty_threshold_i,
    input wire logic wr_en_i,
    input wire logic [DW-1:0] wr_data_i,
    output logic wr_ready_o,
    input wire logic rd_en_i,
    output logic [DW-1:0] rd_data_o,
    output logic rd_valid_o,
    output logic empty_flag_o,
    output logic full_flag_o,
    output logic almost_full_flag_o,
    output logic almost_empty_flag_o,
    output logic [15:0] fill_level_difference_o
);
    localparam int MAW = $clog2(MEM_WORDS);

    typedef struct packed {
        logic [MEM_WORDS-1:0][DW-1:0] mem; // Data storage
        logic [FFAL_PTR_W-1:0] wptr;       // Write address counter
        logic [FFAL_PTR_W-1:0] rptr;       // Read address counter
        logic [1:0] clr_sync;              // Clear synchroniser
        logic [DW-1:0] stage;              // Pipelined read stage
        logic stage_vld;                   // Stage holds a word
        logic [DW-1:0] rdata;              // Read data output
        logic rvld;                        // Read data valid pulse
        logic empty;
        logic full;
        logic almost_full_flag;
        logic almost_empty_flag;
        logic [FFAL_FILL_W-1:0] fill;
    } ffal_core_s;

    ffal_core_s s_q, s_d;
    logic buf_valid, buf_ready;           // Buffer drain handshake
    logic [DW-1:0] buf_data;              // Word leaving the buffer
    logic [2:0] casc, wsel;               // Clamped selections
    logic [4:0] low_bit, top_bit;         // Active address range
    logic [FFAL_PTR_W-1:0] act_mask;      // Active bits incl. wrap
    logic [FFAL_PTR_W-1:0] step;          // Counter increment
    logic [FFAL_PTR_W-1:0] fill_level_difference;          // Masked write minus read
    logic [FFAL_THR_W-1:0] thr_mask;      // Active threshold bits
    logic [FFAL_THR_W-1:0] cmp_fill_level_difference;      // Difference bits compared
    logic do_rd;                          // Read taken this cycle

    // Entry buffer; the counters drain it only while not full
    ffal_buf #(.DW(DW), .DEPTH(BUF_DEPTH)) u_buf (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(wr_en_i),
        .in_ready_o(wr_ready_o),
        .in_data_i(wr_data_i),
        .out_valid_o(buf_valid),
        .out_ready_i(buf_ready),
        .out_data_o(buf_data)
    );

    // Active range: out-of-range codes clamp rather than misaddress
    always_comb begin
        casc = (casc_sel_i > 3'(FFAL_MAX_CASC)) ? 3'(FFAL_MAX_CASC)
                                                 : casc_sel_i;
        wsel = (width_sel_i > 3'(FFAL_MAX_WSEL)) ? 3'(FFAL_MAX_WSEL)
                                                  : width_sel_i;
        low_bit = 5'(FFAL_BASE_LOW) - 5'(wsel);
        top_bit = 5'(FFAL_BASE_TOP) + 5'(casc);
        step = FFAL_PTR_W'(1) << low_bit;
        for (int i = 0; i < FFAL_PTR_W; i++) begin
            act_mask[i] = (5'(i) >= low_bit) && (5'(i) <= top_bit + 5'h1);
        end
        thr_mask = FFAL_THR_ONES >> (3'(FFAL_MAX_CASC) - casc);
    end

    // Counter, memory, read data and flag evaluation
    always_comb begin
        s_d = s_q;
        s_d.clr_sync = {s_q.clr_sync[0], clr_pin_i};
        buf_ready = !s_q.full && !s_q.clr_sync[1];
        do_rd = rd_en_i && !s_q.empty && !s_q.clr_sync[1];
        s_d.rvld = 1'b0;
        s_d.stage_vld = 1'b0;
        if (s_q.clr_sync[1]) begin
            // Clear empties the FIFO and drops any read in flight
            s_d.wptr = '0;
            s_d.rptr = '0;
        end else begin
            if (buf_valid && buf_ready) begin
                // Index wraps at MEM_WORDS; deep modes need a bigger store
                s_d.mem[MAW'(s_q.wptr >> low_bit)] = buf_data;
                s_d.wptr = (s_q.wptr + step) & act_mask;
            end
            if (do_rd) begin
                s_d.rptr = (s_q.rptr + step) & act_mask;
                if (pipelined_i) begin
                    // Pipelined mode trades a cycle for a clean output
                    s_d.stage = s_q.mem[MAW'(s_q.rptr >> low_bit)];
                    s_d.stage_vld = 1'b1;
                end else begin
                    s_d.rdata = s_q.mem[MAW'(s_q.rptr >> low_bit)];
                    s_d.rvld = 1'b1;
                end
            end
            if (s_q.stage_vld) begin
                s_d.rdata = s_q.stage;
                s_d.rvld = 1'b1;
            end
        end
        // Flags follow the counters' next values
        fill_level_difference = (s_d.wptr - s_d.rptr) & act_mask;
        s_d.full = fill_level_difference[top_bit + 5'h1];
        s_d.fill = FFAL_FILL_W'(fill_level_difference) &
                   FFAL_FILL_W'(act_mask >> 1);
        s_d.empty = (fill_level_difference == '0);
        cmp_fill_level_difference = s_d.fill[FFAL_CMP_LSB +: FFAL_THR_W] & thr_mask;
        s_d.almost_full_flag = s_d.full ||
            (cmp_fill_level_difference >= (almost_full_threshold_i & thr_mask));
        s_d.almost_empty_flag = !s_d.full &&
            (cmp_fill_level_difference <= (almost_empty_threshold_i & thr_mask));
    end

    // State register; reset leaves the FIFO empty
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_q <= '0;
            s_q.empty <= 1'b1;
            s_q.almost_empty_flag <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data_o = s_q.rdata;
    assign rd_valid_o = s_q.rvld;
    assign empty_flag_o = s_q.empty;
    assign full_flag_o = s_q.full;
    assign almost_full_flag_o = s_q.almost_full_flag;
    assign almost_empty_flag_o = s_q.almost_empty_flag;
    assign fill_level_difference_o = s_q.fill;
endmodule : ffal_core

//--- core/ffal_pkg.sv
// Constants shared by the FIFO address and flag logic.
// Assumes a single-clock fabric around the block.
package ffal_pkg;
    localparam int FFAL_PTR_W = 17;       // Address bits plus a wrap bit
    localparam int FFAL_FILL_W = 16;      // Fill-level difference width
    localparam int FFAL_THR_W = 8;        // Threshold field width
    localparam int FFAL_BASE_LOW = 5;     // Lowest always-active bit
    localparam int FFAL_BASE_TOP = 11;    // Highest bit without cascade
    localparam int FFAL_CMP_LSB = 8;      // Lowest difference bit compared
    localparam int FFAL_MAX_CASC = 4;     // Cascade code for 16 blocks
    localparam int FFAL_MAX_WSEL = 5;     // Narrowest width code
    localparam int FFAL_REF_DEPTH = 4096; // Single block reference depth
    localparam int FFAL_BUF_DEPTH = 8;    // Entry buffer words
    localparam int FFAL_DEF_DW = 8;       // Default data width
    localparam logic [2:0] FFAL_SEL_ZERO = 3'h0;
    localparam logic [7:0] FFAL_THR_ONES = 8'hff;
endpackage : ffal_pkg

//--- tb/ffal_core_sva.sv
// Port checker for the FIFO counter and flag core.
// Bound into every ffal_core; sees its ports only.
`timescale 1ns/10ps
module ffal_core_sva (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic clr_pin_i,
    input wire logic [2:0] width_sel_i,
    input wire logic [2:0] casc_sel_i,
    input wire logic pipelined_i,
    input wire logic [7:0] almost_full_threshold_i,
    input wire logic [7:0] almost_empty_threshold_i,
    input wire logic rd_en_i,
    input wire logic rd_valid_o,
    input wire logic empty_flag_o,
    input wire logic full_flag_o,
    input wire logic almost_full_flag_o,
    input wire logic almost_empty_flag_o,
    input wire logic [15:0] fill_level_difference_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Read taken while the synchronised clear has been quiet
    sequence s_rd;
        rd_en_i && !empty_flag_o && !$past(clr_pin_i)
            && !$past(clr_pin_i, 2) && !$past(clr_pin_i, 3);
    endsequence
    AST_RD_DIRECT: assert property (
        !pipelined_i ##0 s_rd |=> rd_valid_o)
        else $error("direct read gave no strobe");
    AST_RD_PIPE: assert property (
        pipelined_i ##0 s_rd |-> ##2 rd_valid_o)
        else $error("pipelined read gave no strobe");
    AST_RD_CAUSE: assert property (
        rd_valid_o |-> $past(rd_en_i) || $past(rd_en_i, 2))
        else $error("read strobe without request");
    AST_HI_ZERO: assert property (casc_sel_i <= 3'h4 |->
        (fill_level_difference_o >> (5'h0c + casc_sel_i)) == 16'h0000)
        else $error("fill bits above range not zero");
    AST_LO_ZERO: assert property (width_sel_i <= 3'h5 |->
        (fill_level_difference_o << (5'h0b + width_sel_i)) == 16'h0000)
        else $error("inactive low fill bits not zero");
    AST_AF_FULL: assert property (full_flag_o |-> almost_full_flag_o)
        else $error("full without almost full");
    AST_AE_EMPTY: assert property (
        empty_flag_o |-> almost_empty_flag_o && !full_flag_o)
        else $error("empty without almost empty");
    AST_AF_CMP: assert property (
        casc_sel_i == 3'h0 && !full_flag_o && $past(rstn_i)
        && $stable(almost_full_threshold_i) |-> almost_full_flag_o ==
        (fill_level_difference_o[11:8] >= almost_full_threshold_i[3:0]))
        else $error("almost full compare wrong");
    AST_AE_CMP: assert property (casc_sel_i == 3'h0 && !full_flag_o
        && $stable(almost_empty_threshold_i) |-> almost_empty_flag_o ==
        (fill_level_difference_o[11:8] <= almost_empty_threshold_i[3:0]))
        else $error("almost empty compare wrong");
endmodule : ffal_core_sva
bind ffal_core ffal_core_sva u_ffal_core_sva (.clk_i(clk_i), .rstn_i(rstn_i),
    .clr_pin_i(clr_pin_i), .width_sel_i(width_sel_i), .casc_sel_i(casc_sel_i),
    .pipelined_i(pipelined_i), .rd_en_i(rd_en_i), .rd_valid_o(rd_valid_o),
    .almost_full_threshold_i(almost_full_threshold_i),
    .almost_empty_threshold_i(almost_empty_threshold_i),
    .empty_flag_o(empty_flag_o), .full_flag_o(full_flag_o),
    .almost_full_flag_o(almost_full_flag_o),
    .almost_empty_flag_o(almost_empty_flag_o),
    .fill_level_difference_o(fill_level_difference_o));

//--- tb/ffal_core_tb.sv
// Bench for ffal_core: writes via the user model, reads and judges.
// Assumes package, core, model and checker are compiled first.
`timescale 1ns/10ps
module ffal_core_tb import ffal_pkg::*;;
    logic clk = 1'b0;
    logic rstn, clr, pip, req, rd_en, wr_en, wr_ready, rd_valid;
    logic empty, full, almost_full_flag, almost_empty_flag;
    logic [2:0] wsel, csel;
    logic [7:0] af_thr, ae_thr, wr_data, rd_data, sent, exp_rd;
    logic [15:0] fill;
    int errors = 0;
    int samples_checked = 0;
    always #4 clk = ~clk;
    ffal_core u_ffal_core (.clk_i(clk), .rstn_i(rstn), .clr_pin_i(clr),
        .width_sel_i(wsel), .casc_sel_i(csel), .pipelined_i(pip),
        .almost_full_threshold_i(af_thr), .almost_empty_threshold_i(ae_thr),
        .wr_en_i(wr_en), .wr_data_i(wr_data), .wr_ready_o(wr_ready),
        .rd_en_i(rd_en), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
        .empty_flag_o(empty), .full_flag_o(full), .almost_full_flag_o(almost_full_flag),
        .almost_empty_flag_o(almost_empty_flag), .fill_level_difference_o(fill));
    ffal_user_model u_ffal_user_model (.clk_i(clk), .wr_req_i(req),
        .wr_ready_i(wr_ready), .wr_en_o(wr_en), .wr_data_o(wr_data),
        .sent_o(sent));
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    // Write n words; bounded wait, then let the buffer settle
    task automatic put(input int n);
        int i;
        logic [7:0] goal;
        goal = sent + 8'(n);
        req = 1'b1;
        for (i = 0; i < 400 && sent !== goal; i++) @(negedge clk);
        req = 1'b0;
        // A stalled write counts as a mismatch and ends the run
        if (sent !== goal) begin
            chk(sent, goal);
            report_and_stop();
        end
        repeat (12) @(negedge clk);
    endtask : put
    // Back-to-back reads; pipelined data lands one cycle later
    task automatic get(input int n);
        rd_en = 1'b1;
        for (int k = 0; k < n + int'(pip); k++) begin
            @(negedge clk);
            if (k == n - 1) rd_en = 1'b0;
            if (k >= int'(pip)) begin
                chk(rd_valid, 1'b1);
                chk(rd_data, exp_rd);
                exp_rd++;
            end
        end
        @(negedge clk);
    endtask : get
    // Widest words, no cascade: steps, thresholds, full, drain
    task automatic t_base;
        chk({empty, almost_empty_flag, full, almost_full_flag}, 4'hc);
        put(1);
        chk(fill, 16'h0020);
        get(1);
        chk(empty, 1'b1);
        put(15);
        chk({almost_full_flag, almost_empty_flag}, 2'h1);
        put(1);
        chk({almost_full_flag, almost_empty_flag, fill}, 18'h20200);
        put(120);
        chk({full, wr_ready, fill[15:12]}, 6'h20);
        get(136);
        chk(empty, 1'b1);
        $display("base test finished");
    endtask : t_base
    // Mid width, four blocks: low bit 3, upper threshold bits ignored
    task automatic t_mid;
        rstn = 1'b0;
        wsel = 3'h2;
        csel = 3'h2;
        af_thr = 8'hc1;
        ae_thr = 8'h40;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        put(1);
        chk(fill, 16'h0008);
        put(31);
        chk({almost_full_flag, almost_empty_flag, fill}, 18'h20100);
        get(32);
        chk({empty, almost_empty_flag, almost_full_flag}, 3'h6);
        $display("mid test finished");
    endtask : t_mid
    // Narrowest words, sixteen blocks, pipelined read, clear
    task automatic t_wide;
        rstn = 1'b0;
        wsel = 3'h5;
        csel = 3'h4;
        pip = 1'b1;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        put(1);
        chk(fill, 16'h0001);
        get(1);
        put(2);
        clr = 1'b1;
        repeat (6) @(negedge clk);
        clr = 1'b0;
        repeat (4) @(negedge clk);
        chk({empty, almost_empty_flag, fill}, 18'h30000);
        $display("wide test finished");
    endtask : t_wide
    initial begin
        {rstn, clr, pip, req, rd_en, wsel, csel} = '0;
        af_thr = 8'hf2;
        ae_thr = 8'hf1;
        exp_rd = 8'h00;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        t_base();
        t_mid();
        t_wide();
        report_and_stop();
    end
endmodule : ffal_core_tb

//--- tb/ffal_user_model.sv
// Write-side user logic: an incrementing byte stream.
// Assumes the bench moves wr_req_i at falling edges only.
`timescale 1ns/10ps
module ffal_user_model (
    input wire logic clk_i,
    input wire logic wr_req_i,
    input wire logic wr_ready_i,
    output logic wr_en_o,
    output logic [7:0] wr_data_o,
    output logic [7:0] sent_o
);
    logic [7:0] sent_q = 8'h00; // Words taken so far, also next value
    assign sent_o = sent_q;
    // Data garbled while idle so stale values never look valid
    assign wr_en_o = wr_req_i;
    assign wr_data_o = wr_req_i ? sent_q : ~sent_q;
    // Advance only on a taken word; request held until then
    always @(posedge clk_i) begin
        if (wr_en_o && wr_ready_i) begin
            sent_q <= sent_q + 8'h01;
        end
    end
endmodule : ffal_user_model
